// >>> hfp_pkg.sv
package hfp_pkg;

  // Consecutive over-limit switching cycles before hiccup
  localparam logic [2:0] OC_CYCLES_TO_HICCUP = 3'h7;
  // Soft-start charge/discharge cycles spent in hiccup
  localparam logic [2:0] HICCUP_SS_CYCLES    = 3'h7;
  localparam logic [2:0] CNT_RESET           = 3'h0;

  typedef enum logic [3:0] {
    HFP_RESTART = 4'h1,
    HFP_RUN     = 4'h2,
    HFP_HICCUP  = 4'h4,
    HFP_IDLE    = 4'h8
  } hfp_state_e;

endpackage

// >>> hfp_power_ok.sv
`timescale 1ns/1ps
// Open-drain power-good pull-down selection by master/slave role
module hfp_power_ok (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic is_master,
  input  wire logic feedback_sense_out_of_window,
  input  wire logic soft_start_active,
  input  wire logic input_undervoltage_lockout,
  input  wire logic short_circuit,
  input  wire logic over_warning_temp,
  output logic      power_ok_out,
  output logic      power_ok_oe
);

  typedef struct packed {
    logic pull_low;
  } hfp_pok_s;

  hfp_pok_s st;
  hfp_pok_s next_st;
  logic     slave_bad;
  logic     master_bad;

  always_comb begin
    slave_bad  = input_undervoltage_lockout | over_warning_temp;
    master_bad = slave_bad | feedback_sense_out_of_window | soft_start_active | short_circuit;
    next_st.pull_low = is_master ? master_bad : slave_bad;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{pull_low: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Output level is always low; only the enable moves
  assign power_ok_out = 1'b0;
  assign power_ok_oe  = st.pull_low;

  never_high_a: assert property (@(posedge clk) disable iff (reset)
    power_ok_oe |-> !power_ok_out)
    else $error("power ok driven high");
  master_ss_a: assert property (@(posedge clk) disable iff (reset)
    (is_master && soft_start_active) |=> power_ok_oe)
    else $error("master ss not pulling low");
  master_cond_a: assert property (@(posedge clk) disable iff (reset)
    (is_master && (feedback_sense_out_of_window || input_undervoltage_lockout || short_circuit
      || over_warning_temp)) |=> power_ok_oe)
    else $error("master fault not pulling low");
  master_clear_a: assert property (@(posedge clk) disable iff (reset)
    (is_master && !feedback_sense_out_of_window && !soft_start_active && !input_undervoltage_lockout
      && !short_circuit && !over_warning_temp) |=> !power_ok_oe)
    else $error("master pulled low without cause");
  slave_cond_a: assert property (@(posedge clk) disable iff (reset)
    (!is_master && (input_undervoltage_lockout || over_warning_temp)) |=> power_ok_oe)
    else $error("slave fault not pulling low");
  slave_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (!is_master && !input_undervoltage_lockout && !over_warning_temp) |=> !power_ok_oe)
    else $error("slave pulled low without cause");

endmodule // hfp_power_ok

// >>> hfp_hiccup.sv
`timescale 1ns/1ps
module hfp_hiccup (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic is_master,
  input  wire logic switch_cycle,
  input  wire logic pwm_request,
  input  wire logic above_current_limit_level,
  input  wire logic ss_cycle_done,
  input  wire logic ss_ramp_done,
  input  wire logic feedback_sense_out_of_window,
  input  wire logic input_undervoltage_lockout,
  input  wire logic short_circuit,
  input  wire logic over_warning_temp,
  output logic      high_side_on,
  output logic      low_side_on,
  output logic      hiccup_active,
  output logic      soft_start_active,
  output logic      prebias_reset,
  output logic      overcurrent_event,
  output logic      power_ok_out,
  output logic      power_ok_oe
);

  typedef struct packed {
    hfp_pkg::hfp_state_e state;
    logic [2:0]          oc_cnt;
    logic [2:0]          ss_cnt;
    logic                hs;
    logic                ls;
    logic                prebias_rst;
    logic                oc_evt;
    logic                hic;
    logic                ssa;
  } hfp_hic_s;

  hfp_hic_s st;
  hfp_hic_s next_st;
  logic     oc_hit;

  always_comb begin
    next_st             = st;
    next_st.prebias_rst = 1'b0;
    next_st.oc_evt      = 1'b0;
    oc_hit              = 1'b0;
    case (st.state)
      hfp_pkg::HFP_IDLE: begin
        next_st.oc_cnt = hfp_pkg::CNT_RESET;
        next_st.ss_cnt = hfp_pkg::CNT_RESET;
        if (enable && !input_undervoltage_lockout) begin
          next_st.state = hfp_pkg::HFP_RESTART;
        end
      end
      hfp_pkg::HFP_RESTART, hfp_pkg::HFP_RUN: begin
        if (switch_cycle) begin
          if (!above_current_limit_level || !is_master) begin
            next_st.oc_cnt = hfp_pkg::CNT_RESET;
          end else if (st.oc_cnt == hfp_pkg::OC_CYCLES_TO_HICCUP - 3'h1) begin
            oc_hit = 1'b1;
          end else begin
            next_st.oc_cnt = st.oc_cnt + 3'h1;
          end
        end
        if (!enable || input_undervoltage_lockout) begin
          next_st.state = hfp_pkg::HFP_IDLE;
        end else if (oc_hit) begin
          next_st.state       = hfp_pkg::HFP_HICCUP;
          next_st.oc_cnt      = hfp_pkg::CNT_RESET;
          next_st.ss_cnt      = hfp_pkg::CNT_RESET;
          next_st.prebias_rst = 1'b1;
          next_st.oc_evt      = 1'b1;
        end else if (st.state == hfp_pkg::HFP_RESTART && ss_ramp_done) begin
          next_st.state = hfp_pkg::HFP_RUN;
        end
      end
      hfp_pkg::HFP_HICCUP: begin
        if (!enable || input_undervoltage_lockout) begin
          next_st.state = hfp_pkg::HFP_IDLE;
        end else if (ss_cycle_done) begin
          if (st.ss_cnt == hfp_pkg::HICCUP_SS_CYCLES - 3'h1) begin
            next_st.state  = hfp_pkg::HFP_RESTART;
            next_st.ss_cnt = hfp_pkg::CNT_RESET;
          end else begin
            next_st.ss_cnt = st.ss_cnt + 3'h1;
          end
        end
      end
      default: begin
        next_st.state = hfp_pkg::HFP_IDLE;
      end
    endcase
    // Drives follow PWM only when switching is allowed; restart never pulls low-side on alone
    if (next_st.state == hfp_pkg::HFP_RUN || next_st.state == hfp_pkg::HFP_RESTART) begin
      next_st.hs = pwm_request;
      next_st.ls = !pwm_request && (next_st.state == hfp_pkg::HFP_RUN);
    end else begin
      next_st.hs = 1'b0;
      next_st.ls = 1'b0;
    end
    next_st.hic = (next_st.state == hfp_pkg::HFP_HICCUP);
    next_st.ssa = (next_st.state != hfp_pkg::HFP_RUN);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{state: hfp_pkg::HFP_IDLE, oc_cnt: hfp_pkg::CNT_RESET, ss_cnt: hfp_pkg::CNT_RESET,
              hs: 1'b0, ls: 1'b0, prebias_rst: 1'b0, oc_evt: 1'b0, hic: 1'b0, ssa: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign high_side_on      = st.hs;
  assign low_side_on       = st.ls;
  assign hiccup_active     = st.hic;
  assign soft_start_active = st.ssa;
  assign prebias_reset     = st.prebias_rst;
  assign overcurrent_event = st.oc_evt;

  hfp_power_ok i_hfp_power_ok (
    .clk                          (clk),
    .reset                        (reset),
    .is_master                    (is_master),
    .feedback_sense_out_of_window (feedback_sense_out_of_window),
    .soft_start_active            (soft_start_active),
    .input_undervoltage_lockout   (input_undervoltage_lockout),
    .short_circuit                (short_circuit),
    .over_warning_temp            (over_warning_temp),
    .power_ok_out                 (power_ok_out),
    .power_ok_oe                  (power_ok_oe)
  );

  // Seventh consecutive over-limit cycle seen by a master in restart or run
  sequence s_oc_run7;
    (switch_cycle && above_current_limit_level && is_master && enable && !input_undervoltage_lockout)
      && st.oc_cnt == 3'h6 && st.state != hfp_pkg::HFP_HICCUP && st.state != hfp_pkg::HFP_IDLE;
  endsequence

  sequence s_entry_pulses;
    hiccup_active && prebias_reset && overcurrent_event;
  endsequence

  // Last soft-start cycle of a hiccup that is not cut short
  sequence s_ss_last;
    hiccup_active && ss_cycle_done && st.ss_cnt == 3'h6 && enable && !input_undervoltage_lockout;
  endsequence

  sequence s_cleared_restart;
    st.state == hfp_pkg::HFP_RESTART && ss_ramp_done && !oc_hit && enable && !input_undervoltage_lockout;
  endsequence

  oc_entry_a: assert property (@(posedge clk) disable iff (reset)
    s_oc_run7 |=> s_entry_pulses)
    else $error("no hiccup after 7 cycles");
  oc_cnt_bound_a: assert property (@(posedge clk) disable iff (reset)
    st.oc_cnt <= 3'h6)
    else $error("oc counter past limit");
  cnt_clear_a: assert property (@(posedge clk) disable iff (reset)
    (switch_cycle && !above_current_limit_level && !hiccup_active) |=> st.oc_cnt == 3'h0)
    else $error("oc counter not cleared");

  drives_off_a: assert property (@(posedge clk) disable iff (reset)
    hiccup_active |-> !high_side_on && !low_side_on)
    else $error("drive on in hiccup");
  idle_off_a: assert property (@(posedge clk) disable iff (reset)
    (!enable || input_undervoltage_lockout) |=> !hiccup_active && !high_side_on && !low_side_on)
    else $error("drive on while disabled");

  hiccup_exit_a: assert property (@(posedge clk) disable iff (reset)
    s_ss_last |=> !hiccup_active && soft_start_active)
    else $error("hiccup exit wrong");
  early_exit_a: assert property (@(posedge clk) disable iff (reset)
    (hiccup_active && st.ss_cnt < 3'h6 && enable && !input_undervoltage_lockout) |=> hiccup_active)
    else $error("hiccup left early");
  ss_cnt_bound_a: assert property (@(posedge clk) disable iff (reset)
    st.ss_cnt <= 3'h6)
    else $error("soft-start counter past limit");
  ss_zero_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == hfp_pkg::HFP_RESTART || st.state == hfp_pkg::HFP_RUN) |-> st.ss_cnt == 3'h0)
    else $error("soft-start count left over");

  fresh_entry_a: assert property (@(posedge clk) disable iff (reset)
    $rose(hiccup_active) |-> st.ss_cnt == 3'h0 && prebias_reset)
    else $error("hiccup entry not fresh");
  restart_clean_a: assert property (@(posedge clk) disable iff (reset)
    s_ss_last |=> st.oc_cnt == 3'h0 && st.state == hfp_pkg::HFP_RESTART)
    else $error("restart not clean");
  run_ok_a: assert property (@(posedge clk) disable iff (reset)
    s_cleared_restart |=> st.state == hfp_pkg::HFP_RUN)
    else $error("restart did not resume");
  run_follow_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == hfp_pkg::HFP_RUN && enable && !input_undervoltage_lockout && !oc_hit)
      |=> high_side_on == $past(pwm_request) && low_side_on == !$past(pwm_request))
    else $error("run drives do not follow pwm");

  no_discharge_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == hfp_pkg::HFP_RESTART) |-> !low_side_on)
    else $error("restart discharges output");
  low_side_run_a: assert property (@(posedge clk) disable iff (reset)
    low_side_on |-> st.state == hfp_pkg::HFP_RUN && !high_side_on)
    else $error("low side on outside run");
  entry_once_a: assert property (@(posedge clk) disable iff (reset)
    prebias_reset |=> !prebias_reset)
    else $error("prebias reset held");

  slave_no_oc_a: assert property (@(posedge clk) disable iff (reset)
    !is_master |=> !overcurrent_event)
    else $error("slave declared overcurrent");
  slave_no_hiccup_a: assert property (@(posedge clk) disable iff (reset)
    (!is_master && !hiccup_active) |=> !hiccup_active)
    else $error("slave entered hiccup");
  oc_master_a: assert property (@(posedge clk) disable iff (reset)
    overcurrent_event |-> $past(is_master))
    else $error("overcurrent without master");

endmodule // hfp_hiccup

// >>> hfp_stage_model.sv
`timescale 1ns/1ps
// Power stage plus pulled-up power-good line
module hfp_stage_model (
  input  wire logic clk,
  input  wire logic high_side_on,
  input  wire logic low_side_on,
  input  wire logic power_ok_out,
  input  wire logic power_ok_oe,
  output logic      pg_line,
  output int        faults
);
  assign pg_line = power_ok_oe ? power_ok_out : 1'b1;
  initial faults = 0;
  // Driving high or shoot-through
  always @(negedge clk) begin
    if ((power_ok_oe && power_ok_out !== 1'b0) || (high_side_on && low_side_on)) begin
      faults <= faults + 1;
    end
  end
endmodule // hfp_stage_model

// >>> hfp_hiccup_tb.sv
`timescale 1ns/1ps
module hfp_hiccup_tb;
  logic       clk, reset, enable, is_master, sw, pwm, over, ss_done, ramp;
  logic [3:0] cond;
  logic       hs, ls, hic, ssa, pb, oc, pgo, pgoe, pg_line;
  int         faults, num_errors, checks_done, n_pb, n_oc;
  hfp_hiccup i_hfp_hiccup (.clk(clk), .reset(reset), .enable(enable), .is_master(is_master),
    .switch_cycle(sw), .pwm_request(pwm), .above_current_limit_level(over), .ss_cycle_done(ss_done),
    .ss_ramp_done(ramp), .feedback_sense_out_of_window(cond[0]), .short_circuit(cond[1]),
    .over_warning_temp(cond[2]), .input_undervoltage_lockout(cond[3]), .high_side_on(hs),
    .low_side_on(ls), .hiccup_active(hic), .soft_start_active(ssa), .prebias_reset(pb),
    .overcurrent_event(oc), .power_ok_out(pgo), .power_ok_oe(pgoe));
  hfp_stage_model i_hfp_stage_model (.clk(clk), .high_side_on(hs), .low_side_on(ls),
    .power_ok_out(pgo), .power_ok_oe(pgoe), .pg_line(pg_line), .faults(faults));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    n_pb += (pb === 1'b1);
    n_oc += (oc === 1'b1);
  end
  task automatic chk(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sw_pulses(int n, logic lvl);
    over = lvl;
    repeat (n) begin
      sw = 1'b1;
      tick(1);
      sw = 1'b0;
      tick(1);
    end
  endtask
  task automatic pulse_ss(int n);
    repeat (n) begin
      ss_done = 1'b1;
      tick(1);
      ss_done = 1'b0;
      tick(1);
    end
  endtask
  task automatic to_run();
    ramp = 1'b1;
    tick(1);
    ramp = 1'b0;
    tick(2);
  endtask
  task automatic t_count();
    sw_pulses(6, 1'b1);
    sw_pulses(1, 1'b0);
    sw_pulses(6, 1'b1);
    tick(1);
    chk("hiccup early", 1'b0, hic);
    sw_pulses(1, 1'b1);
    tick(1);
    chk("hiccup", 1'b1, hic);
    chk("high side", 1'b0, hs);
    chk("low side", 1'b0, ls);
    chk("prebias pulse", 1'b1, n_pb == 1);
    chk("oc pulse", 1'b1, n_oc == 1);
  endtask
  task automatic t_hiccup();
    pwm = 1'b0;
    pulse_ss(6);
    chk("hiccup held", 1'b1, hic);
    chk("hiccup low side", 1'b0, ls);
    pulse_ss(1);
    tick(1);
    chk("restart", 1'b0, hic);
    chk("restart low side", 1'b0, ls);
    pwm = 1'b1;
    to_run();
    chk("run high side", 1'b1, hs);
    chk("soft start", 1'b0, ssa);
    pwm = 1'b0;
    tick(2);
    chk("run low side", 1'b1, ls);
    chk("run high side off", 1'b0, hs);
    pwm = 1'b1;
    sw_pulses(7, 1'b0);
    chk("no hiccup", 1'b0, hic);
    sw_pulses(7, 1'b1);
    tick(1);
    chk("fresh hiccup", 1'b1, hic);
    chk("second oc", 1'b1, n_oc == 2);
  endtask
  task automatic t_slave();
    sw_pulses(10, 1'b1);
    tick(1);
    chk("slave hiccup", 1'b0, hic);
    chk("slave oc", 1'b1, n_oc == 2);
    over = 1'b0;
  endtask
  task automatic t_pg(logic [3:0] low_mask, int n);
    for (int k = 0; k < n; k++) begin
      cond = 4'h1 << k;
      tick(2);
      chk("power good", ~low_mask[k], pg_line);
      cond = 4'h0;
      tick(2);
      chk("power good clear", 1'b1, pg_line);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {enable, sw, over, ss_done, ramp, cond} = '0;
    {is_master, pwm} = 2'b11;
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    enable = 1'b1;
    tick(2);
    to_run();
    t_count();
    t_hiccup();
    pulse_ss(7);
    tick(1);
    to_run();
    t_pg(4'h7, 3);
    cond = 4'h8;
    tick(2);
    chk("lockout power good", 1'b0, pg_line);
    cond = 4'h0;
    tick(3);
    chk("soft start power good", 1'b0, pg_line);
    is_master = 1'b0;
    to_run();
    t_slave();
    t_pg(4'hc, 4);
    chk("line faults", 1'b1, faults == 0);
    test_done();
  end
  initial begin
    #200us;
    num_errors++;
    test_done();
  end
endmodule // hfp_hiccup_tb
